// *** src/i2cml_pkg.sv ***
// constants and types of the i2c master transaction launch block
package i2cml_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TIMEOUT_US = 2000; // exceeds a four-byte 100 kHz transfer
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] REQ_IDX = 10'h08B;
  localparam logic [9:0] CFG_IDX = 10'h080;
  localparam logic [9:0] STAT_IDX = 10'h081;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h082;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h083;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] REQ_RESET = 16'h2800;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CFG_RDTR_EN_BIT = 0;
  localparam int unsigned CFG_TO_EN_BIT = 1;
  localparam int unsigned CFG_PTR_LEN_BIT = 2;
  localparam int unsigned CFG_WALT_BIT = 3;
  localparam int unsigned CFG_TEN_BIT_BIT = 4;
  localparam int unsigned ST_STATE_LO = 14;
  localparam int unsigned ST_REJECT_BIT = 8;
  localparam int unsigned ST_RDTR_BIT = 1;
  localparam int unsigned ST_TIMEOUT_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_TIMEOUT_BIT = 1;
  localparam int unsigned IRQ_RDTR_BIT = 2;
  localparam int unsigned IRQ_REJECT_BIT = 3;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] TS_NONE = 2'h0;
  localparam logic [1:0] TS_BUSY = 2'h1;
  localparam logic [1:0] TS_ERROR = 2'h2;
  localparam logic [1:0] TS_DONE = 2'h3;
  localparam logic [1:0] LEN_ONE = 2'h0;
  localparam logic [1:0] LEN_TWO = 2'h1;
  localparam logic [1:0] LEN_THREE = 2'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {FSM_IDLE, FSM_ACTIVE} i2cml_fsm_type;

  typedef struct packed {
    logic pointer_byte_select;
    logic [1:0] data_length_field;
    logic [1:0] data_location_field;
    logic [2:0] slave_address_high_bits;
    logic [6:0] slave_address_low_bits;
    logic transaction_direction_bit;
  } i2cml_req_type;

  typedef struct packed {
    logic [9:0] slave_addr;
    logic ten_bit;
    logic read;
    logic send_pointer_byte_zero;
    logic send_pointer_byte_one;
    logic [2:0] byte_count;
    logic [1:0] msb_location;
    logic redundant;
  } i2cml_launch_type;

endpackage : i2cml_pkg

// *** src/i2cml_top.sv ***
// i2c master transaction request, launch, error flags and register slave
//
// Contract
// - with a redundant read running, a second read word unlike the first sets status bit 1.
// - the redundant comparison and its flag work only while redundant_read_enable is one.
// - a transaction outliving the timeout sets status bit 0, only while timeout_enable is one.
// - both error flags stay set until written zero; writing one leaves them as they are.
// - every accepted write of the request register launches one transaction from its fields.
// - a request write while busy is dropped, the register is kept, and the reject flag rises.
// - reading the request register returns the last accepted request.
// - request bit 15 picks pointer byte zero or one.
// - with two-byte pointers configured the pick is ignored and both bytes go out.
// - bits 14:13 give the length: one, two (reset), three, four bytes.
// - in alternate write mode code 10 on a write means zero bytes; reads keep three.
// - bits 12:11 name the data byte holding the most significant byte, reset 01.
// - bits 10:8 give address bits 9:7 in ten-bit mode and are ignored in seven-bit mode.
// - bits 7:1 give address bits 6:0.
// - bit 0 picks write (zero, reset) or read (one).
// - state field 15:14 reads none, busy, error, done; cleared by writing zero or a new request.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
module i2cml_top #(
  parameter int unsigned TIMEOUT_CYC = i2cml_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // bus engine side
  output logic launch_o,
  output i2cml_pkg::i2cml_launch_type launch_cfg_o,
  output logic abort_o,
  input wire logic eng_done_i,
  input wire logic eng_error_i,
  input wire logic eng_rd_valid_i,
  input wire logic [31:0] eng_rd_data_i,
  // interrupt
  output logic irq_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // address decode, shared by read and write paths
  function automatic logic reg_hit(input logic [31:0] adr, input logic [9:0] idx);
    reg_hit = (adr[31:12] == 20'h00000) && (adr[11:2] == idx);
  endfunction : reg_hit

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] sel);
    lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : lane_merge

  // length code to byte count
  function automatic logic [2:0] byte_count(input logic [1:0] len, input logic rd,
                                            input logic walt);
    case (len)
      i2cml_pkg::LEN_ONE: byte_count = 3'h1;
      i2cml_pkg::LEN_TWO: byte_count = 3'h2;
      i2cml_pkg::LEN_THREE: byte_count = (walt && !rd) ? 3'h0 : 3'h3;
      default: byte_count = 3'h4;
    endcase
  endfunction : byte_count

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  i2cml_pkg::i2cml_req_type req_r;
  logic [4:0] cfg_r;
  logic [1:0] tstate_r;
  logic to_flag_r;
  logic rdtr_flag_r;
  logic reject_flag_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  i2cml_pkg::i2cml_fsm_type fsm_r;
  logic [31:0] to_cnt_r;
  logic rdn_r;
  logic first_seen_r;
  logic [31:0] first_word_r;
  logic mm_seen_r;
  logic launch_r;
  i2cml_pkg::i2cml_launch_type launch_cfg_r;
  logic abort_r;

  // ---------------------------------------------------------------
  // bus decode and events
  // ---------------------------------------------------------------
  logic wb_req;
  logic wr_fire;
  logic req_wr;
  logic accept;
  logic reject;
  logic cfg_wr;
  logic stat_wr;
  logic irq_stat_wr;
  logic irq_mask_wr;
  logic busy;
  logic timeout_ev;
  logic mismatch_ev;
  logic finish_ev;
  logic [15:0] req_new;
  logic [3:0] irq_ev;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_fire = wb_req && wb_we_i && ack_r; // writes act on the ack edge
  assign req_wr = wr_fire && reg_hit(wb_adr_i, i2cml_pkg::REQ_IDX);
  assign cfg_wr = wr_fire && reg_hit(wb_adr_i, i2cml_pkg::CFG_IDX);
  assign stat_wr = wr_fire && reg_hit(wb_adr_i, i2cml_pkg::STAT_IDX);
  assign irq_stat_wr = wr_fire && reg_hit(wb_adr_i, i2cml_pkg::IRQ_STAT_IDX);
  assign irq_mask_wr = wr_fire && reg_hit(wb_adr_i, i2cml_pkg::IRQ_MASK_IDX);
  assign busy = (fsm_r == i2cml_pkg::FSM_ACTIVE);
  assign accept = req_wr && !busy;
  assign reject = req_wr && busy;
  assign req_new = lane_merge(req_r, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign timeout_ev = busy && cfg_r[i2cml_pkg::CFG_TO_EN_BIT]
                      && (to_cnt_r == TIMEOUT_CYC - 1);
  assign mismatch_ev = busy && rdn_r && first_seen_r && eng_rd_valid_i
                       && (eng_rd_data_i != first_word_r);
  assign finish_ev = busy && (eng_done_i || eng_error_i || timeout_ev);
  assign irq_ev = {reject, mismatch_ev, timeout_ev, finish_ev};

  // ---------------------------------------------------------------
  // wishbone handshake and read data
  // ---------------------------------------------------------------
  // one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req && !ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h00000000;
    end else if (wb_req && !ack_r) begin
      rdat_r <= 32'h00000000;
      if (reg_hit(wb_adr_i, i2cml_pkg::REQ_IDX)) begin
        rdat_r[15:0] <= req_r;
      end else if (reg_hit(wb_adr_i, i2cml_pkg::CFG_IDX)) begin
        rdat_r[4:0] <= cfg_r;
      end else if (reg_hit(wb_adr_i, i2cml_pkg::STAT_IDX)) begin
        rdat_r[i2cml_pkg::ST_STATE_LO+:2] <= tstate_r;
        rdat_r[i2cml_pkg::ST_REJECT_BIT] <= reject_flag_r;
        rdat_r[i2cml_pkg::ST_RDTR_BIT] <= rdtr_flag_r;
        rdat_r[i2cml_pkg::ST_TIMEOUT_BIT] <= to_flag_r;
      end else if (reg_hit(wb_adr_i, i2cml_pkg::IRQ_STAT_IDX)) begin
        rdat_r[3:0] <= irq_stat_r;
      end else if (reg_hit(wb_adr_i, i2cml_pkg::IRQ_MASK_IDX)) begin
        rdat_r[3:0] <= irq_mask_r;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------------------------------------------------------
  // request and configuration registers
  // ---------------------------------------------------------------
  // request kept while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_r <= i2cml_pkg::REQ_RESET;
    end else if (accept) begin
      req_r <= req_new;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= i2cml_pkg::CFG_RESET;
    end else if (cfg_wr && wb_sel_i[0]) begin
      cfg_r <= wb_dat_i[4:0];
    end
  end

  // ---------------------------------------------------------------
  // transaction sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsm_r <= i2cml_pkg::FSM_IDLE;
    end else begin
      case (fsm_r)
        i2cml_pkg::FSM_IDLE: begin
          if (accept) begin
            fsm_r <= i2cml_pkg::FSM_ACTIVE;
          end
        end
        i2cml_pkg::FSM_ACTIVE: begin
          if (finish_ev) begin
            fsm_r <= i2cml_pkg::FSM_IDLE;
          end
        end
        default: fsm_r <= i2cml_pkg::FSM_IDLE;
      endcase
    end
  end

  // timeout counter from start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_r <= 32'h00000000;
    end else if (!busy) begin
      to_cnt_r <= 32'h00000000;
    end else begin
      to_cnt_r <= to_cnt_r + 32'h00000001;
    end
  end

  // redundant read word capture and compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdn_r <= 1'b0;
      first_seen_r <= 1'b0;
      first_word_r <= 32'h00000000;
      mm_seen_r <= 1'b0;
    end else if (accept) begin
      rdn_r <= cfg_r[i2cml_pkg::CFG_RDTR_EN_BIT] && req_new[0];
      first_seen_r <= 1'b0;
      mm_seen_r <= 1'b0;
    end else if (busy && eng_rd_valid_i && !first_seen_r) begin
      first_seen_r <= 1'b1;
      first_word_r <= eng_rd_data_i;
    end else if (mismatch_ev) begin
      mm_seen_r <= 1'b1;
    end
  end

  // launch request toward the bus engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch_r <= 1'b0;
      launch_cfg_r <= '0;
      abort_r <= 1'b0;
    end else begin
      launch_r <= accept;
      abort_r <= timeout_ev;
      if (accept) begin
        launch_cfg_r.slave_addr <= cfg_r[i2cml_pkg::CFG_TEN_BIT_BIT]
                                   ? req_new[10:1] : {3'h0, req_new[7:1]};
        launch_cfg_r.ten_bit <= cfg_r[i2cml_pkg::CFG_TEN_BIT_BIT];
        launch_cfg_r.read <= req_new[0];
        launch_cfg_r.send_pointer_byte_zero <= cfg_r[i2cml_pkg::CFG_PTR_LEN_BIT]
                                               || !req_new[15];
        launch_cfg_r.send_pointer_byte_one <= cfg_r[i2cml_pkg::CFG_PTR_LEN_BIT]
                                              || req_new[15];
        launch_cfg_r.byte_count <= byte_count(req_new[14:13], req_new[0],
                                              cfg_r[i2cml_pkg::CFG_WALT_BIT]);
        launch_cfg_r.msb_location <= req_new[12:11];
        launch_cfg_r.redundant <= cfg_r[i2cml_pkg::CFG_RDTR_EN_BIT] && req_new[0];
      end
    end
  end

  assign launch_o = launch_r;
  assign launch_cfg_o = launch_cfg_r;
  assign abort_o = abort_r;

  // ---------------------------------------------------------------
  // status field and sticky error flags
  // ---------------------------------------------------------------
  // state field: hardware update wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tstate_r <= i2cml_pkg::TS_NONE;
    end else if (accept) begin
      tstate_r <= i2cml_pkg::TS_BUSY;
    end else if (finish_ev) begin
      tstate_r <= (eng_error_i || timeout_ev || mm_seen_r || mismatch_ev)
                  ? i2cml_pkg::TS_ERROR : i2cml_pkg::TS_DONE;
    end else if (stat_wr && wb_sel_i[1]
                 && wb_dat_i[i2cml_pkg::ST_STATE_LO+:2] == i2cml_pkg::TS_NONE) begin
      tstate_r <= i2cml_pkg::TS_NONE;
    end
  end

  // flags cleared by a zero, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_flag_r <= 1'b0;
    end else if (timeout_ev) begin
      to_flag_r <= 1'b1;
    end else if (stat_wr && wb_sel_i[0] && !wb_dat_i[i2cml_pkg::ST_TIMEOUT_BIT]) begin
      to_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdtr_flag_r <= 1'b0;
    end else if (mismatch_ev) begin
      rdtr_flag_r <= 1'b1;
    end else if (stat_wr && wb_sel_i[0] && !wb_dat_i[i2cml_pkg::ST_RDTR_BIT]) begin
      rdtr_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reject_flag_r <= 1'b0;
    end else if (reject) begin
      reject_flag_r <= 1'b1;
    end else if (stat_wr && wb_sel_i[1] && !wb_dat_i[i2cml_pkg::ST_REJECT_BIT]) begin
      reject_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 4'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((irq_stat_wr && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0))
                    | irq_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= i2cml_pkg::IRQ_MASK_RESET;
    end else if (irq_mask_wr && wb_sel_i[0]) begin
      irq_mask_r <= wb_dat_i[3:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_mismatch_sets_flag: assert property (mismatch_ev |=> rdtr_flag_r ##0 tstate_r != 2'h0)
    else $error("redundant mismatch did not set flag");
  a_rdtr_enable_gate: assert property ($rose(rdtr_flag_r) |-> $past(rdn_r))
    else $error("redundant flag rose without enable");
  a_timeout_sets_flag: assert property (timeout_ev |=> to_flag_r && abort_o && !busy)
    else $error("timeout did not set flag and abort");
  a_timeout_gate: assert property ($rose(to_flag_r) |-> $past(cfg_r[1]))
    else $error("timeout flag rose while disabled");
  a_flags_sticky: assert property (to_flag_r && !stat_wr |=> to_flag_r)
    else $error("timeout flag dropped without clear");
  a_write_one_keeps: assert property (rdtr_flag_r && stat_wr && wb_sel_i[0] && wb_dat_i[1]
                                      |=> rdtr_flag_r)
    else $error("writing one cleared the redundant flag");
  a_accept_launches: assert property (accept |=> launch_o && busy && tstate_r == 2'h1)
    else $error("accepted request did not launch");
  a_reject_keeps_req: assert property (reject |=> $stable(req_r) && reject_flag_r
                                        && !launch_o)
    else $error("rejected request changed state");
  a_ptr_select: assert property (launch_o |-> launch_cfg_o.send_pointer_byte_zero
                                   == ($past(cfg_r[2]) || !req_r[15]))
    else $error("pointer byte zero selection wrong");
  a_both_ptrs: assert property (launch_o && $past(cfg_r[2]) |-> launch_cfg_o.send_pointer_byte_zero
                                  && launch_cfg_o.send_pointer_byte_one)
    else $error("two-byte pointer mode sent one byte");
  a_len_four: assert property (launch_o && req_r[14:13] == 2'h3
                               |-> launch_cfg_o.byte_count == 3'h4)
    else $error("length code 11 not four bytes");
  a_walt_zero_len: assert property (launch_o && req_r[14:13] == 2'h2 && !req_r[0]
                                    && $past(cfg_r[3]) |-> launch_cfg_o.byte_count == 3'h0)
    else $error("alternate write length not zero");
  a_addr_seven: assert property (launch_o && !launch_cfg_o.ten_bit
                                 |-> launch_cfg_o.slave_addr == {3'h0, req_r[7:1]})
    else $error("seven-bit address wrong");
  a_state_done: assert property (busy && eng_done_i && !eng_error_i && !timeout_ev
                                 && !mm_seen_r && !mismatch_ev |=> tstate_r == 2'h3)
    else $error("state field not complete after done");

  c_launch: cover property (accept ##1 launch_o);
  c_reject: cover property (reject);
  c_timeout: cover property (timeout_ev);
  c_mismatch: cover property (mismatch_ev ##[1:20] eng_done_i);

endmodule : i2cml_top

// *** testbench/i2cml_engine_model.sv ***
// bus engine stand-in that finishes transfers and streams read words
`timescale 1ns/100ps
module i2cml_engine_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // launch side
  input wire logic launch_i,
  input wire logic abort_i,
  input wire logic hang_i,
  input wire logic fail_i,
  // answers
  output logic done_o,
  output logic error_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o
);
  logic run_r;
  logic [31:0] cnt_r;

  // ---------------------------------------------------------------
  // transfer progress
  // ---------------------------------------------------------------
  // run flag, dropped on finish or abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'h0;
    end else if (launch_i) begin
      run_r <= 1'h1;
    end else if (abort_i || done_o || error_o) begin
      run_r <= 1'h0;
    end
  end

  // cycle count since launch
  always_ff @(posedge clk_i) begin
    if (rst_i || launch_i) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // two read words, then completion unless told to hang
  assign done_o = run_r && (cnt_r == 32'h13) && !hang_i && !fail_i;
  // same finish point, reported as a failed transfer
  assign error_o = run_r && (cnt_r == 32'h13) && !hang_i && fail_i;
  assign rd_valid_o = run_r && (cnt_r == 32'h5 || cnt_r == 32'hA);
  // data changes every cycle, so a stale word never passes as fresh
  assign rd_data_o = 32'hC3C3_0000 ^ cnt_r;
endmodule : i2cml_engine_model

// *** testbench/i2c_master_transaction_launch_tb.sv ***
// self-checking bench of the transaction launch block
`timescale 1ns/100ps
module i2c_master_transaction_launch_tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [31:0] rdata;
  logic wb_ack_o, launch_o, abort_o, irq_o, done, rvalid;
  logic hang = 1'h0;
  logic fail = 1'h0;
  logic err;
  int aborts = 0;
  i2cml_pkg::i2cml_launch_type launch_cfg_o;
  int err_count = 0;
  int tests_run = 0;

  initial forever #4 clk_i = ~clk_i;

  i2cml_top #(.TIMEOUT_CYC(40)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .launch_o(launch_o),
    .launch_cfg_o(launch_cfg_o), .abort_o(abort_o), .eng_done_i(done), .eng_error_i(err),
    .eng_rd_valid_i(rvalid), .eng_rd_data_i(rdata), .irq_o(irq_o));

  i2cml_engine_model peer (.clk_i(clk_i), .rst_i(rst_i), .launch_i(launch_o),
    .abort_i(abort_o), .hang_i(hang), .fail_i(fail), .done_o(done), .error_o(err),
    .rd_valid_o(rvalid), .rd_data_o(rdata));

  // count abort pulses toward the engine
  always @(posedge clk_i) if (abort_o === 1'h1) aborts++;

  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_cfg(input i2cml_pkg::i2cml_launch_type exp);
    tests_run++;
    if (launch_o !== 1'h1 || launch_cfg_o !== exp) begin
      err_count++;
      $display("[FAIL] %0t launch %b cfg %h expected %h", $time, launch_o, launch_cfg_o, exp);
    end
  endtask : chk_cfg

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one classic cycle, released at the ack edge
  task automatic wb(input logic we, input logic [9:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {20'h0, idx, 2'h0};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    #1;
  endtask : wb

  task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp);
    wb(1'h0, idx, 16'h0);
    chk16(rd[15:0], exp);
  endtask : rdchk

  // poll the state field until the transfer is no longer busy
  task automatic wait_end;
    int n;
    n = 0;
    do begin
      wb(1'h0, i2cml_pkg::STAT_IDX, 16'h0);
      n++;
    end while (rd[15:14] === 2'h1 && n < 60);
  endtask : wait_end

  // clear flags, launch, check the launch and the final status
  task automatic run(input logic [15:0] req, input i2cml_pkg::i2cml_launch_type exp,
                     input logic [15:0] st);
    wb(1'h1, i2cml_pkg::STAT_IDX, 16'h0);
    wb(1'h1, i2cml_pkg::IRQ_STAT_IDX, 16'hF);
    wb(1'h1, i2cml_pkg::REQ_IDX, req);
    chk_cfg(exp);
    rdchk(i2cml_pkg::REQ_IDX, req);
    wait_end;
    chk16(rd[15:0], st);
  endtask : run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    rdchk(i2cml_pkg::REQ_IDX, 16'h2800);
    rdchk(i2cml_pkg::CFG_IDX, 16'h0000);
    rdchk(10'h0F0, 16'h0000);
    rdchk(i2cml_pkg::STAT_IDX, 16'h0000);
    wb(1'h1, i2cml_pkg::CFG_IDX, 16'h0010);
    wb(1'h1, i2cml_pkg::IRQ_MASK_IDX, 16'h0009);
    wb(1'h1, i2cml_pkg::REQ_IDX, 16'hF56A);
    chk_cfg('{10'h2B5, 1'h1, 1'h0, 1'h0, 1'h1, 3'h4, 2'h2, 1'h0});
    rdchk(i2cml_pkg::STAT_IDX, 16'h4000);
    wb(1'h1, i2cml_pkg::REQ_IDX, 16'h1234);
    chk16({15'h0, launch_o}, 16'h0000);
    rdchk(i2cml_pkg::REQ_IDX, 16'hF56A);
    wait_end;
    chk16(rd[15:0], 16'hC100);
    chk16({15'h0, irq_o}, 16'h0001);
    rdchk(i2cml_pkg::IRQ_STAT_IDX, 16'h0009);
    wb(1'h1, i2cml_pkg::IRQ_STAT_IDX, 16'h0009);
    chk16({15'h0, irq_o}, 16'h0000);
    wb(1'h1, i2cml_pkg::STAT_IDX, 16'hFFFF);
    rdchk(i2cml_pkg::STAT_IDX, 16'hC100);
    // timeout on a hung seven-bit write
    wb(1'h1, i2cml_pkg::CFG_IDX, 16'h0002);
    hang <= 1'h1;
    run(16'h0702, '{10'h001, 1'h0, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0}, 16'h8001);
    wb(1'h1, i2cml_pkg::STAT_IDX, 16'hFFFF);
    rdchk(i2cml_pkg::STAT_IDX, 16'h8001);
    chk16(aborts[15:0], 16'h0001);
    hang <= 1'h0;
    // redundant read with both pointers and alternate writes
    wb(1'h1, i2cml_pkg::CFG_IDX, 16'h000D);
    run(16'h48A1, '{10'h050, 1'h0, 1'h1, 1'h1, 1'h1, 3'h3, 2'h1, 1'h1}, 16'h8002);
    wb(1'h1, i2cml_pkg::STAT_IDX, 16'hFFFF);
    rdchk(i2cml_pkg::STAT_IDX, 16'h8002);
    wb(1'h1, i2cml_pkg::STAT_IDX, 16'h0000);
    rdchk(i2cml_pkg::STAT_IDX, 16'h0000);
    run(16'h4020, '{10'h010, 1'h0, 1'h0, 1'h1, 1'h1, 3'h0, 2'h0, 1'h0}, 16'hC000);
    wb(1'h1, i2cml_pkg::CFG_IDX, 16'h0000);
    run(16'h48A1, '{10'h050, 1'h0, 1'h1, 1'h1, 1'h0, 3'h3, 2'h1, 1'h0}, 16'hC000);
    // engine reports a failed transfer
    fail <= 1'h1;
    run(16'h48A1, '{10'h050, 1'h0, 1'h1, 1'h1, 1'h0, 3'h3, 2'h1, 1'h0}, 16'h8000);
    fail <= 1'h0;
    // hung transfer without timeout stays busy
    hang <= 1'h1;
    run(16'h0002, '{10'h001, 1'h0, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0}, 16'h4000);
    chk16(aborts[15:0], 16'h0001);
    final_report;
  end

  // watchdog against a hung bus or handshake
  initial begin
    #(8 * 20000);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
endmodule : i2c_master_transaction_launch_tb
